// File: design/line_event_detect.sv
`timescale 1ns/10ps
module line_event_detect (
    // Clock and reset.
    input  wire logic                             clk,
    input  wire logic                             reset_n,
    // Buffer kind and mode.
    input  wire logic [line_mux_pkg::NBUF-1:0]    is_teletype,
    input  wire logic [line_mux_pkg::NBUF-1:0]    input_mode,
    // Line conditions.
    input  wire logic [line_mux_pkg::NBUF-1:0]    modem_line_signal,
    input  wire logic [line_mux_pkg::NBUF-1:0]    tty_input_signal,
    input  wire logic [line_mux_pkg::NBUF-1:0]    tty_eom_char,
    // Message events.
    output logic      [line_mux_pkg::NBUF-1:0]    msg_event
);

    logic [line_mux_pkg::NBUF-1:0] sig_prev_q;
    logic [line_mux_pkg::NBUF-1:0] sig_prev_d;
    logic [line_mux_pkg::NBUF-1:0] sig_now;

    ////////////////////////////////////////////////////////////////////////////
    // Loss of received signal ends a modem message; a rising signal starts one.
    genvar g;
    generate
        for (g = 0; g < line_mux_pkg::NBUF; g++) begin : g_buf
            logic rise;
            logic fall;
            logic eom;
            assign sig_now[g] = is_teletype[g] ? tty_input_signal[g] : modem_line_signal[g];
            assign rise = sig_now[g] & ~sig_prev_q[g];
            assign fall = ~sig_now[g] & sig_prev_q[g];
            assign eom  = is_teletype[g] ? tty_eom_char[g] : fall;
            assign msg_event[g] = input_mode[g] ? eom : rise;  // [R11] [R12]
        end
    endgenerate

    always_comb begin
        sig_prev_d = sig_now;
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sig_prev_q <= line_mux_pkg::MODE_RESET;
        end else begin
            sig_prev_q <= sig_prev_d;
        end
    end

endmodule

// File: design/line_mux_pkg.sv
package line_mux_pkg;

    // Host word and controller geometry.
    localparam int unsigned HOST_W        = 18;
    localparam int unsigned NBUF          = 8;
    localparam int unsigned BUF_IDX_W     = 3;
    localparam int unsigned ADDR_W        = 8;
    localparam int unsigned OPD_W         = 8;

    // Device addresses (octal 040 and octal 300).
    localparam logic [ADDR_W-1:0] CTRL_ADDR_BASE = 8'h20;
    localparam logic [ADDR_W-1:0] BUF_ADDR_BASE  = 8'hC0;
    localparam logic [ADDR_W-1:0] BUF_ADDR_SPAN  = 8'h40;

    // Mode control word: bit n of the host word is index n-1.
    localparam int unsigned CW_OUT_LSB    = 0;
    localparam int unsigned CW_IN_LSB     = 8;

    // Operating data fields in the accumulator.
    localparam int unsigned WSIZE_W       = 5;
    localparam int unsigned OPD_WSIZE_LSB = 1;
    localparam int unsigned OPD_EOM_LSB   = 8;

    // Interrupt status word halves.
    localparam int unsigned IS_EXH_LSB    = 0;
    localparam int unsigned IS_MSG_LSB    = 8;

    // Buffer status word bit positions.
    localparam int unsigned ST_DSR        = 15;
    localparam int unsigned ST_CTS        = 14;
    localparam int unsigned ST_RI         = 13;
    localparam int unsigned ST_DCD        = 12;
    localparam int unsigned ST_SQ         = 11;
    localparam int unsigned ST_IN_MODE    = 10;
    localparam int unsigned ST_OUT_MODE   = 9;
    localparam int unsigned ST_SVC_REQ    = 8;
    localparam int unsigned ST_WSIZE_LSB  = 2;
    localparam int unsigned ST_TTY_EOM    = 15;
    localparam int unsigned ST_TTY_SIG    = 12;
    localparam int unsigned ST_EOM_LSB    = 0;

    // Reset values.
    localparam logic [NBUF-1:0]   MODE_RESET  = 8'h00;
    localparam logic [2*NBUF-1:0] INT_RESET   = 16'h0000;
    localparam logic [HOST_W-1:0] RDATA_RESET = 18'h00000;
    localparam logic [OPD_W-1:0]  OPD_RESET   = 8'h00;

    typedef enum logic [1:0] {
        RD_NONE,
        RD_INT_STATUS,
        RD_BUFFER
    } read_kind_e;

endpackage

// File: design/line_mux_program_interface.sv
// Operation
// (R1) Mode control word is written by output command at address 40 plus controller.
// (R2) Each buffer has an output and an input request bit; both zero idles it.
// (R3) Bits 1-8 request output, bits 9-16 input; bits 17-18 ignored.
// (R4) Software writes the whole current state of every buffer each time.
// (R5) Operating data is written by output command at address 300 plus buffer.
// (R6) Modem operating data is a five-bit word size field.
// (R7) Teletype operating data is the end-of-message code from bits 9-16.
// (R8) Operating data is kept until software writes it again.
// (R9) The controller drives its own interrupt request line.
// (R10) Interrupt status is read by input command at address 040 plus controller.
// (R11) End of message in input mode sets the buffer's message status bit.
// (R12) Incoming signal start outside input mode sets the message status bit.
// (R13) Block exhausted raises its bit and stops that buffer's input and output.
// (R14) Software then rewrites pointer words and requests the mode again.
// (R15) Data received without input mode is discarded, never stored.
// (R16) Software services a buffer interrupt within about 1.6 ms.
// (R17) Buffer status is read by input command at address 300 plus buffer.
// (R18) Status bits read one when true and zero when false.
// (R19) Modem status reports modem lines at bits 16 down to 12.
// (R20) Bits 11, 10 and 9 report input mode, output mode, service request.
// (R21) Modem status returns word size in bits 3-8; bits 1-2 unused.
// (R22) Teletype status: end of message 16, signal 13, code in bits 1-8.
`timescale 1ns/10ps
module line_mux_program_interface #(
    parameter logic [line_mux_pkg::BUF_IDX_W-1:0] CONTROLLER_NUMBER = 3'h0
) (
    // Clock and reset.
    input  wire logic                                   clk,
    input  wire logic                                   reset_n,
    // Host programmed I/O.
    input  wire logic                                   io_out_strobe,
    input  wire logic                                   io_read_instruction,
    input  wire logic [line_mux_pkg::ADDR_W-1:0]        io_addr,
    input  wire logic [line_mux_pkg::HOST_W-1:0]        io_wdata,
    output logic                                        io_addr_claim,
    output logic      [line_mux_pkg::HOST_W-1:0]        io_rdata,
    output logic                                        io_rdata_valid,
    // Interrupt to the host.
    output logic                                        interrupt_request,
    // Buffer kind straps.
    input  wire logic [line_mux_pkg::NBUF-1:0]          buffer_is_teletype,
    // Modem lines per buffer.
    input  wire logic [line_mux_pkg::NBUF-1:0]          modem_data_set_ready,
    input  wire logic [line_mux_pkg::NBUF-1:0]          modem_clear_to_send,
    input  wire logic [line_mux_pkg::NBUF-1:0]          modem_ring_indicator,
    input  wire logic [line_mux_pkg::NBUF-1:0]          modem_line_signal,
    input  wire logic [line_mux_pkg::NBUF-1:0]          modem_signal_quality,
    // Teletype lines per buffer.
    input  wire logic [line_mux_pkg::NBUF-1:0]          tty_input_signal,
    input  wire logic [line_mux_pkg::NBUF-1:0]          tty_eom_char,
    // Buffer and transfer engine conditions.
    input  wire logic [line_mux_pkg::NBUF-1:0]          buffer_service_req,
    input  wire logic [line_mux_pkg::NBUF-1:0]          block_exhausted,
    input  wire logic [line_mux_pkg::NBUF-1:0]          rx_word_valid,
    // Controls to the buffers.
    output logic      [line_mux_pkg::NBUF-1:0]          output_mode,
    output logic      [line_mux_pkg::NBUF-1:0]          input_mode,
    output logic      [line_mux_pkg::NBUF-1:0]          rx_store_enable,
    // Operating data to the buffers.
    input  wire logic [line_mux_pkg::BUF_IDX_W-1:0]     op_data_sel,
    output logic      [line_mux_pkg::OPD_W-1:0]         op_data_out
);

    ////////////////////////////////////////////////////////////////////////////
    // Address decode.

    function automatic logic ctrl_hit(input logic [line_mux_pkg::ADDR_W-1:0] a);
        logic [line_mux_pkg::ADDR_W-1:0] own;

        own = line_mux_pkg::CTRL_ADDR_BASE
            + {{(line_mux_pkg::ADDR_W-line_mux_pkg::BUF_IDX_W){1'b0}}, CONTROLLER_NUMBER};
        return a == own;
    endfunction

    function automatic logic buf_hit(input logic [line_mux_pkg::ADDR_W-1:0] a);
        logic [line_mux_pkg::ADDR_W-1:0] rel;

        rel = a - line_mux_pkg::BUF_ADDR_BASE;
        return (a >= line_mux_pkg::BUF_ADDR_BASE)
            && (rel < line_mux_pkg::BUF_ADDR_SPAN)
            && (rel[2*line_mux_pkg::BUF_IDX_W-1:line_mux_pkg::BUF_IDX_W]
                == CONTROLLER_NUMBER);
    endfunction

    function automatic logic [line_mux_pkg::BUF_IDX_W-1:0] buf_index(
        input logic [line_mux_pkg::ADDR_W-1:0] a);
        return a[line_mux_pkg::BUF_IDX_W-1:0];
    endfunction

    logic                                   wr_ctrl;
    logic                                   wr_buf;
    logic                                   rd_ctrl;
    logic                                   rd_buf;
    logic [line_mux_pkg::BUF_IDX_W-1:0]     addr_idx;

    always_comb begin
        wr_ctrl  = io_out_strobe && ctrl_hit(io_addr);         // [R1]
        wr_buf   = io_out_strobe && buf_hit(io_addr);          // [R5]

        rd_ctrl  = io_read_instruction && ctrl_hit(io_addr);   // [R10]
        rd_buf   = io_read_instruction && buf_hit(io_addr);    // [R17]
        addr_idx = buf_index(io_addr);

        io_addr_claim = wr_ctrl || wr_buf || rd_ctrl || rd_buf;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Mode control word.

    logic [line_mux_pkg::NBUF-1:0] out_req_q;
    logic [line_mux_pkg::NBUF-1:0] out_req_d;

    logic [line_mux_pkg::NBUF-1:0] in_req_q;
    logic [line_mux_pkg::NBUF-1:0] in_req_d;

    // An exhausted block stops the buffer even if a write lands in the same cycle.
    always_comb begin
        out_req_d = out_req_q;
        in_req_d  = in_req_q;

        if (wr_ctrl) begin
            out_req_d = io_wdata[line_mux_pkg::CW_OUT_LSB +: line_mux_pkg::NBUF];  // [R2] [R3]
            in_req_d  = io_wdata[line_mux_pkg::CW_IN_LSB +: line_mux_pkg::NBUF];   // [R2] [R3]
        end

        out_req_d = out_req_d & ~block_exhausted;  // [R13]
        in_req_d  = in_req_d & ~block_exhausted;   // [R13]
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_req_q <= line_mux_pkg::MODE_RESET;
            in_req_q  <= line_mux_pkg::MODE_RESET;
        end else begin
            out_req_q <= out_req_d;
            in_req_q  <= in_req_d;
        end
    end

    always_comb begin
        output_mode     = out_req_q;
        input_mode      = in_req_q;
        rx_store_enable = rx_word_valid & in_req_q;  // [R15]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Operating data store.

    logic [line_mux_pkg::OPD_W-1:0] opd_wdata;
    logic [line_mux_pkg::OPD_W-1:0] opd_host;

    always_comb begin
        if (buffer_is_teletype[addr_idx]) begin
            opd_wdata = io_wdata[line_mux_pkg::OPD_EOM_LSB +: line_mux_pkg::OPD_W];  // [R7]
        end else begin
            opd_wdata = {{(line_mux_pkg::OPD_W-line_mux_pkg::WSIZE_W){1'b0}},
                         io_wdata[line_mux_pkg::OPD_WSIZE_LSB +: line_mux_pkg::WSIZE_W]};  // [R6]
        end
    end

    operating_data_store u_store (
        .clk       (clk),
        .reset_n   (reset_n),
        .wr_en     (wr_buf),
        .wr_idx    (addr_idx),
        .wr_data   (opd_wdata),
        .host_idx  (addr_idx),
        .host_data (opd_host),
        .line_idx  (op_data_sel),
        .line_data (op_data_out)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt status word.

    logic [line_mux_pkg::NBUF-1:0]   msg_event;
    logic [2*line_mux_pkg::NBUF-1:0] int_q;
    logic [2*line_mux_pkg::NBUF-1:0] int_d;
    logic [2*line_mux_pkg::NBUF-1:0] int_set;

    logic [2*line_mux_pkg::NBUF-1:0] snap_q;
    logic [2*line_mux_pkg::NBUF-1:0] snap_d;

    line_event_detect u_events (
        .clk               (clk),
        .reset_n           (reset_n),
        .is_teletype       (buffer_is_teletype),
        .input_mode        (in_req_q),
        .modem_line_signal (modem_line_signal),
        .tty_input_signal  (tty_input_signal),
        .tty_eom_char      (tty_eom_char),
        .msg_event         (msg_event)
    );

    // Reading the word clears it; an event in the reading cycle survives.
    always_comb begin
        int_set = '0;
        int_set[line_mux_pkg::IS_EXH_LSB +: line_mux_pkg::NBUF] = block_exhausted;  // [R13]
        int_set[line_mux_pkg::IS_MSG_LSB +: line_mux_pkg::NBUF] = msg_event;  // [R11] [R12]

        snap_d = snap_q;
        int_d  = int_q | int_set;

        if (rd_ctrl) begin
            snap_d = int_q;
            int_d  = int_set;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            int_q  <= line_mux_pkg::INT_RESET;
            snap_q <= line_mux_pkg::INT_RESET;
        end else begin
            int_q  <= int_d;
            snap_q <= snap_d;
        end
    end

    always_comb begin
        interrupt_request = |int_q;  // [R9]
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read pipeline: take, then assemble, then present.

    line_mux_pkg::read_kind_e           kind_q;
    line_mux_pkg::read_kind_e           kind_d;
    logic [line_mux_pkg::BUF_IDX_W-1:0] ridx_q;
    logic [line_mux_pkg::BUF_IDX_W-1:0] ridx_d;

    logic [line_mux_pkg::HOST_W-1:0]    rdata_d;
    logic                               rvalid_d;
    logic [line_mux_pkg::HOST_W-1:0]    word;

    // Stage one notes the kind of read.
    always_comb begin
        kind_d = line_mux_pkg::RD_NONE;
        ridx_d = ridx_q;

        if (rd_ctrl) begin
            kind_d = line_mux_pkg::RD_INT_STATUS;
        end else if (rd_buf) begin
            kind_d = line_mux_pkg::RD_BUFFER;
            ridx_d = addr_idx;
        end
    end

    // Stage two builds the word.
    always_comb begin
        word = '0;

        unique case (kind_q)
            line_mux_pkg::RD_NONE: begin
                word = '0;
            end
            line_mux_pkg::RD_INT_STATUS: begin
                word[2*line_mux_pkg::NBUF-1:0] = snap_q;  // [R10]
            end
            line_mux_pkg::RD_BUFFER: begin
                word[line_mux_pkg::ST_IN_MODE]  = in_req_q[ridx_q];            // [R20]
                word[line_mux_pkg::ST_OUT_MODE] = out_req_q[ridx_q];           // [R20]
                word[line_mux_pkg::ST_SVC_REQ]  = buffer_service_req[ridx_q];  // [R20]

                if (buffer_is_teletype[ridx_q]) begin
                    word[line_mux_pkg::ST_TTY_EOM] =
                        int_q[line_mux_pkg::IS_MSG_LSB + ridx_q] & in_req_q[ridx_q];  // [R22]
                    word[line_mux_pkg::ST_TTY_SIG] = tty_input_signal[ridx_q];       // [R22]
                    word[line_mux_pkg::ST_EOM_LSB +: line_mux_pkg::OPD_W] = opd_host;  // [R22]
                end else begin
                    word[line_mux_pkg::ST_DSR] = modem_data_set_ready[ridx_q];  // [R19] [R18]
                    word[line_mux_pkg::ST_CTS] = modem_clear_to_send[ridx_q];   // [R19]
                    word[line_mux_pkg::ST_RI]  = modem_ring_indicator[ridx_q];  // [R19]
                    word[line_mux_pkg::ST_DCD] = modem_line_signal[ridx_q];     // [R19]
                    word[line_mux_pkg::ST_SQ]  = modem_signal_quality[ridx_q];  // [R19]
                    word[line_mux_pkg::ST_WSIZE_LSB +: line_mux_pkg::WSIZE_W + 1] =
                        {1'b0, opd_host[line_mux_pkg::WSIZE_W-1:0]};  // [R21]
                end
            end
        endcase

        rvalid_d = kind_q != line_mux_pkg::RD_NONE;
        rdata_d  = rvalid_d ? word : io_rdata;
    end

    // Stage three holds the answer.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            kind_q         <= line_mux_pkg::RD_NONE;
            ridx_q         <= '0;
            io_rdata       <= line_mux_pkg::RDATA_RESET;
            io_rdata_valid <= 1'b0;
        end else begin
            kind_q         <= kind_d;
            ridx_q         <= ridx_d;
            io_rdata       <= rdata_d;
            io_rdata_valid <= rvalid_d;
        end
    end

endmodule

// File: design/operating_data_store.sv
`timescale 1ns/10ps
module operating_data_store (
    // Clock and reset.
    input  wire logic                                   clk,
    input  wire logic                                   reset_n,
    // Write port from the host.
    input  wire logic                                   wr_en,
    input  wire logic [line_mux_pkg::BUF_IDX_W-1:0]     wr_idx,
    input  wire logic [line_mux_pkg::OPD_W-1:0]         wr_data,
    // Host read port.
    input  wire logic [line_mux_pkg::BUF_IDX_W-1:0]     host_idx,
    output logic      [line_mux_pkg::OPD_W-1:0]         host_data,
    // Buffer side read port.
    input  wire logic [line_mux_pkg::BUF_IDX_W-1:0]     line_idx,
    output logic      [line_mux_pkg::OPD_W-1:0]         line_data
);

    logic [line_mux_pkg::OPD_W-1:0] mem_q  [line_mux_pkg::NBUF];
    logic [line_mux_pkg::OPD_W-1:0] mem_d  [line_mux_pkg::NBUF];
    logic [line_mux_pkg::OPD_W-1:0] host_d;
    logic [line_mux_pkg::OPD_W-1:0] line_d;

    ////////////////////////////////////////////////////////////////////////////
    // A word is kept until the host writes that buffer again.
    always_comb begin
        for (int i = 0; i < line_mux_pkg::NBUF; i++) begin
            mem_d[i] = mem_q[i];
        end
        if (wr_en) begin
            mem_d[wr_idx] = wr_data;  // [R8]
        end
        host_d = mem_q[host_idx];
        line_d = mem_q[line_idx];
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < line_mux_pkg::NBUF; i++) begin
                mem_q[i] <= line_mux_pkg::OPD_RESET;
            end
            host_data <= line_mux_pkg::OPD_RESET;
            line_data <= line_mux_pkg::OPD_RESET;
        end else begin
            for (int i = 0; i < line_mux_pkg::NBUF; i++) begin
                mem_q[i] <= mem_d[i];
            end
            host_data <= host_d;
            line_data <= line_d;
        end
    end

endmodule

// File: testbench/host_pio_model.sv
`timescale 1ns/10ps
module host_pio_model (
    // Clock.
    input  wire logic                              clk,
    // Programmed I/O commands.
    output logic                                   io_out_strobe,
    output logic                                   io_read_instruction,
    output logic      [line_mux_pkg::ADDR_W-1:0]   io_addr,
    output logic      [line_mux_pkg::HOST_W-1:0]   io_wdata,
    // Read answer.
    input  wire logic [line_mux_pkg::HOST_W-1:0]   io_rdata,
    input  wire logic                              io_rdata_valid
);
    initial begin
        io_out_strobe       = 1'b0;
        io_read_instruction = 1'b0;
        io_addr             = 8'h00;
        io_wdata            = 18'h00000;
    end

    // An output command lasts one cycle; the bus then shows inverted junk.
    task automatic wr(input logic [7:0] a, input logic [17:0] d);
        @(posedge clk);
        io_out_strobe <= 1'b1;
        io_addr       <= a;
        io_wdata      <= d;
        @(posedge clk);
        io_out_strobe <= 1'b0;
        io_addr       <= ~a;
        io_wdata      <= ~d;
    endtask

    // An input command waits a bounded time for the loaded word.
    task automatic rd(input logic [7:0] a, output logic [17:0] d);
        int n;
        d = 18'h3FFFF;
        @(posedge clk);
        io_read_instruction <= 1'b1;
        io_addr             <= a;
        @(posedge clk);
        io_read_instruction <= 1'b0;
        io_addr             <= ~a;
        for (n = 0; n < 6; n++) begin
            @(posedge clk);
            if (io_rdata_valid === 1'b1) begin
                d = io_rdata;
                break;
            end
        end
    endtask
endmodule

// File: testbench/line_mux_monitor.sv
`timescale 1ns/10ps
module line_mux_monitor #(
    parameter logic [2:0] CONTROLLER_NUMBER = 3'h0
) (
    input wire logic        clk,
    input wire logic        reset_n,
    input wire logic        io_out_strobe,
    input wire logic        io_read_instruction,
    input wire logic [7:0]  io_addr,
    input wire logic [17:0] io_wdata,
    input wire logic        io_addr_claim,
    input wire logic [17:0] io_rdata,
    input wire logic        io_rdata_valid,
    input wire logic        interrupt_request,
    input wire logic [7:0]  buffer_is_teletype,
    input wire logic [7:0]  block_exhausted,
    input wire logic [7:0]  rx_word_valid,
    input wire logic [7:0]  output_mode,
    input wire logic [7:0]  input_mode,
    input wire logic [7:0]  rx_store_enable
);
    logic [7:0] ctrl;
    logic       own;
    logic       ctrl_wr;
    logic [7:0] a1_q;
    logic [7:0] a2_q;
    logic [7:0] in_q;
    logic [7:0] out_q;
    assign ctrl    = line_mux_pkg::CTRL_ADDR_BASE + 8'(CONTROLLER_NUMBER);
    assign own     = io_addr == ctrl || io_addr[7:3] == {2'h3, CONTROLLER_NUMBER};
    assign ctrl_wr = io_out_strobe && io_addr == ctrl;
    always_ff @(posedge clk) begin
        a1_q  <= io_addr;
        a2_q  <= a1_q;
        in_q  <= input_mode;
        out_q <= output_mode;
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);
    sequence s_own_read;
        io_read_instruction && own;
    endsequence
    sequence s_buf_answer;
        io_rdata_valid && a2_q[7:6] == 2'h3;
    endsequence

    a_claim_decode: assert property (io_addr_claim ==
        ((io_out_strobe || io_read_instruction) && own))
        else $error("claim does not match address decode");
    a_mode_write: assert property (ctrl_wr && block_exhausted == 8'h00 |=>
        {input_mode, output_mode} == $past(io_wdata[15:0])) else $error("mode bits not loaded");
    a_mode_hold: assert property (!ctrl_wr && block_exhausted == 8'h00 |=>
        $stable(input_mode) && $stable(output_mode)) else $error("mode bits changed unasked");
    a_exhaust_stops: assert property (|block_exhausted |=>
        ((input_mode | output_mode) & $past(block_exhausted)) == 8'h00) else $error("mode kept");
    a_exhaust_irq: assert property (|block_exhausted |-> ##1 interrupt_request)
        else $error("no interrupt after block exhausted");
    a_store_gate: assert property (rx_store_enable == (rx_word_valid & input_mode))
        else $error("received word stored outside input mode");
    a_read_answer: assert property (s_own_read |-> ##2 io_rdata_valid)
        else $error("read not answered in two cycles");
    a_answer_cause: assert property (io_rdata_valid |->
        $past(io_read_instruction && own, 2)) else $error("answer without owned read");
    a_mode_status: assert property (s_buf_answer |-> io_rdata[10] == in_q[a2_q[2:0]] &&
        io_rdata[9] == out_q[a2_q[2:0]]) else $error("mode status bits wrong");
    a_modem_unused: assert property (s_buf_answer ##0 !buffer_is_teletype[a2_q[2:0]] |->
        io_rdata[1:0] == 2'h0 && io_rdata[7] == 1'b0 && io_rdata[17:16] == 2'h0)
        else $error("unused modem status bits set");
endmodule

bind line_mux_program_interface line_mux_monitor #(.CONTROLLER_NUMBER(CONTROLLER_NUMBER))
    line_mux_monitor_i (.clk(clk), .reset_n(reset_n), .io_out_strobe(io_out_strobe),
    .io_read_instruction(io_read_instruction), .io_addr(io_addr), .io_wdata(io_wdata),
    .io_addr_claim(io_addr_claim), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
    .interrupt_request(interrupt_request), .buffer_is_teletype(buffer_is_teletype),
    .block_exhausted(block_exhausted), .rx_word_valid(rx_word_valid),
    .output_mode(output_mode), .input_mode(input_mode), .rx_store_enable(rx_store_enable));

// File: testbench/line_mux_program_interface_tb.sv
`timescale 1ns/10ps
module line_mux_program_interface_tb;
    logic        clk = 1'b0, reset_n = 1'b0, io_out_strobe, io_read_instruction;
    logic [7:0]  io_addr, dsr = 8'h00, cts = 8'h00, ri = 8'h00, dcd = 8'h00, sq = 8'h00;
    logic [7:0]  tsig = 8'h00, teom = 8'h00, svc = 8'h00, exh = 8'h00, rxv = 8'h00;
    logic [7:0]  output_mode, input_mode, rx_store_enable, op_data_out;
    logic [17:0] io_wdata, io_rdata;
    logic [2:0]  op_data_sel = 3'h0;
    logic        io_rdata_valid, interrupt_request;
    int          fail_count = 0, checks = 0, cyc = 0;

    always #5 clk = ~clk;

    line_mux_program_interface #(.CONTROLLER_NUMBER(3'h2)) line_mux_program_interface_i (
        .clk(clk), .reset_n(reset_n), .io_out_strobe(io_out_strobe),
        .io_read_instruction(io_read_instruction), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_addr_claim(), .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid),
        .interrupt_request(interrupt_request), .buffer_is_teletype(8'hF0),
        .modem_data_set_ready(dsr), .modem_clear_to_send(cts), .modem_ring_indicator(ri),
        .modem_line_signal(dcd), .modem_signal_quality(sq), .tty_input_signal(tsig),
        .tty_eom_char(teom), .buffer_service_req(svc), .block_exhausted(exh),
        .rx_word_valid(rxv), .output_mode(output_mode), .input_mode(input_mode),
        .rx_store_enable(rx_store_enable), .op_data_sel(op_data_sel),
        .op_data_out(op_data_out));

    host_pio_model host_pio_model_i (.clk(clk), .io_out_strobe(io_out_strobe),
        .io_read_instruction(io_read_instruction), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_rdata(io_rdata), .io_rdata_valid(io_rdata_valid));

    task automatic chk(input logic [17:0] seen, input logic [17:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [17:0] e);
        logic [17:0] d;
        host_pio_model_i.rd(a, d);
        chk(d, e);
    endtask

    task automatic results();
        if (fail_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            results();
        end
    end

    task automatic t_control();
        host_pio_model_i.wr(8'h22, 18'h3A55C);
        @(posedge clk);
        chk(18'({input_mode, output_mode}), 18'h0A55C);
        host_pio_model_i.wr(8'h21, 18'h00000);
        host_pio_model_i.wr(8'h22, 18'h00200);
        @(posedge clk);
        chk(18'({input_mode, output_mode}), 18'h00200);
    endtask

    task automatic t_opdata();
        host_pio_model_i.wr(8'hD1, 18'h00024);
        host_pio_model_i.wr(8'hD5, 18'h0A700);
        host_pio_model_i.wr(8'hC9, 18'h3FFFF);
        @(posedge clk) op_data_sel <= 3'h1;
        repeat (2) @(posedge clk);
        chk(18'(op_data_out), 18'h00012);
        op_data_sel <= 3'h5;
        repeat (2) @(posedge clk);
        chk(18'(op_data_out), 18'h000A7);
    endtask

    task automatic t_status();
        dsr <= 8'h22;
        ri  <= 8'h02;
        sq  <= 8'h02;
        svc <= 8'h02;
        rdchk(8'hD1, 18'h0AD48);
        rdchk(8'hD5, 18'h000A7);
    endtask

    task automatic t_events();
        @(posedge clk) tsig <= 8'h20;
        repeat (3) @(posedge clk);
        chk(18'(interrupt_request), 18'h00001);
        rdchk(8'h22, 18'h02000);
        rdchk(8'h22, 18'h00000);
        host_pio_model_i.wr(8'h22, 18'h02200);
        @(posedge clk) teom <= 8'h20;
        @(posedge clk) teom <= 8'h00;
        repeat (2) @(posedge clk);
        rdchk(8'hD5, 18'h094A7);
        rdchk(8'h22, 18'h02000);
        @(posedge clk) dcd <= 8'h02;
        repeat (3) @(posedge clk);
        rdchk(8'h22, 18'h00000);
        @(posedge clk) dcd <= 8'h00;
        repeat (3) @(posedge clk);
        rdchk(8'h22, 18'h00200);
        @(posedge clk) exh <= 8'h20;
        @(posedge clk) exh <= 8'h00;
        @(posedge clk);
        chk(18'(input_mode), 18'h00002);
        rdchk(8'h22, 18'h00020);
        chk(18'(interrupt_request), 18'h00000);
        host_pio_model_i.wr(8'h22, 18'h02200);
        @(posedge clk) rxv <= 8'hFF;
        @(posedge clk);
        chk(18'(rx_store_enable), 18'h00022);
    endtask

    initial begin
        repeat (12) @(posedge clk);
        chk(18'({input_mode, output_mode}), 18'h00000);
        chk(18'({interrupt_request, op_data_out}), 18'h00000);
        reset_n <= 1'b1;
        t_control();
        t_opdata();
        t_status();
        t_events();
        results();
    end
endmodule
